/* ece_pkg.sv */
// Purpose: Shared constants, types and pin carriers of the EPP cycle engine.
// Assumes: 200 MHz system clock, registers one per aligned 32-bit word.
// Notes:   Register index times four gives the byte address.
package ece_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned WD_TIME_US    = 10;
  // Longest time, so the count rounds down.
  localparam int unsigned WD_CYCLES     = (WD_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned WD_W          = 16;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int unsigned ADDR_W      = 6;
  localparam logic [3:0]  IDX_DATA    = 4'h0;
  localparam logic [3:0]  IDX_STATUS  = 4'h1;
  localparam logic [3:0]  IDX_CTRL    = 4'h2;
  localparam logic [3:0]  IDX_EPPADDR = 4'h3;
  localparam logic [3:0]  IDX_EPPD0   = 4'h4;
  localparam logic [3:0]  IDX_EPPD3   = 4'h7;
  localparam logic [3:0]  IDX_MODE    = 4'h8;

  // Control register fields.
  localparam int unsigned CTRL_STROBE = 0;
  localparam int unsigned CTRL_AUTOFD = 1;
  localparam int unsigned CTRL_INIT   = 2;
  localparam int unsigned CTRL_SELIN  = 3;
  localparam int unsigned CTRL_PCD    = 5;
  localparam int unsigned CTRL_W      = 6;

  // Status register fields.
  localparam int unsigned STAT_TIMEOUT = 0;

  // Reset values.
  localparam logic [5:0]  CTRL_RESET = 6'h00;
  localparam logic [7:0]  PD_RESET   = 8'h00;
  localparam logic [31:0] RD_RESET   = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_SPP   = 2'b00,
    MODE_BIDIR = 2'b01,
    MODE_EPP19 = 2'b10,
    MODE_EPP17 = 2'b11
  } ece_mode_e;

  localparam ece_mode_e MODE_RESET = MODE_SPP;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WAIT_LOW = 3'b001,
    ST_SETUP    = 3'b010,
    ST_STROBE   = 3'b011,
    ST_DONE     = 3'b100
  } ece_state_e;

  // ==========================================================================
  // Pin carriers
  // ==========================================================================
  typedef struct packed {
    logic       peripheral_wait_n;
    logic       ack_n;
    logic       paper_end;
    logic       selected;
    logic       error_n;
    logic [7:0] parallel_byte_bus;
  } ece_pins_in_s;

  typedef struct packed {
    logic       write_line_n;
    logic       data_strobe_n;
    logic       init_n;
    logic       addr_strobe_n;
    logic [7:0] parallel_byte_bus;
    logic       bus_oe;
    logic       direction_indication;
  } ece_pins_out_s;

  localparam ece_pins_out_s PINS_RESET = '{
    write_line_n:         1'b1,
    data_strobe_n:        1'b1,
    init_n:               1'b0,
    addr_strobe_n:        1'b1,
    parallel_byte_bus:    8'h00,
    bus_oe:               1'b0,
    direction_indication: 1'b0
  };

endpackage : ece_pkg

/* ece_top.sv */
// Purpose: EPP cycle engine of a parallel port, revisions 1.9 and 1.7.
// Assumes: Avalon-MM slave with waitrequest; peripheral pins are asynchronous.
// Notes:   Host wait states are waitrequest held high during an EPP handshake.
//
// Contract
// - Idle port follows control register and direction.
// - Rev 1.9 watchdog runs until wait release.
// - Watchdog expiry aborts cycle, sets timeout flag.
// - Strobe bit forces write direction and line.
// - Write with direction set looks like read.
// - Rev 1.9 stalls host until handshake completes.
// - Rev 1.9 waits for wait low first.
// - Strobe active, complete when wait goes high.
// - Rev 1.9 write: byte, write line, then strobe.
// - Rev 1.9 write: release strobe, then answer.
// - Rev 1.9 read: float bus, release write line.
// - Rev 1.9 read: capture byte, release strobe, answer.
// - Rev 1.7 watchdog spans whole cycle.
// - Rev 1.7 write line follows direction bit.
// - Rev 1.7 strobes, stalls while wait low.
// - Rev 1.7 write end holds byte on bus.
// - Offset 3 address cycle, 4-7 data cycles.
// - Timeout flag cleared by writing one.
`timescale 1ns/1ps

module ece_top
  import ece_pkg::*;
#(
  parameter int unsigned WD_COUNT = ece_pkg::WD_CYCLES
) (
  input  wire logic                  clk_in,
  input  wire logic                  nrst_in,
  input  wire logic                  ce_in,
  input  wire logic [ADDR_W-1:0]     avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [31:0]           avs_writedata_in,
  input  wire logic [3:0]            avs_byteenable_in,
  output logic      [31:0]           avs_readdata_out,
  output logic                       avs_waitrequest_out,
  input  wire ece_pkg::ece_pins_in_s pins_in,
  output ece_pkg::ece_pins_out_s     pins_out
);
  import ece_pkg::*;

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  generate
    if (WD_COUNT < 1 || WD_COUNT >= (1 << WD_W)) begin : g_bad_wd
      $error("WD_COUNT outside the range of the watchdog counter");
    end
  endgenerate

  localparam logic [WD_W-1:0] WD_LAST = WD_W'(WD_COUNT - 1);

  // ==========================================================================
  // Functions
  // ==========================================================================
  function automatic logic is_epp_mode(input ece_mode_e m);
    is_epp_mode = (m == MODE_EPP19) || (m == MODE_EPP17);
  endfunction : is_epp_mode

  function automatic logic is_epp_idx(input logic [3:0] idx);
    is_epp_idx = (idx >= IDX_EPPADDR) && (idx <= IDX_EPPD3);
  endfunction : is_epp_idx

  // ==========================================================================
  // Declarations
  // ==========================================================================
  ece_pins_in_s  pins_meta;
  ece_pins_in_s  pins_sync;
  ece_pins_out_s next_pins;
  ece_state_e    state;
  ece_state_e    next_state;
  ece_mode_e     mode;
  logic [5:0]    ctrl;
  logic [7:0]    pd_reg;
  logic          timeout_flag;
  logic          resp_done;
  logic          cyc_wr;
  logic          cyc_addr;
  logic [WD_W-1:0] wd_cnt;
  logic [3:0]    idx;
  logic          req;
  logic          accept;
  logic          epp_req;
  logic          start;
  logic          wd_expire;
  logic          wait_high;
  logic          rev17;
  logic          port_direction_bit;
  logic          wr_eff;
  logic          timeout_clr;
  logic [7:0]    rd_byte;

  assign idx       = avs_address_in[5:2];
  assign req       = avs_read_in | avs_write_in;
  assign accept    = req & resp_done;
  assign epp_req   = is_epp_mode(mode) & is_epp_idx(idx);
  assign start     = (state == ST_IDLE) & req & ~resp_done & epp_req;
  assign wait_high = pins_sync.peripheral_wait_n;
  assign rev17     = (mode == MODE_EPP17);
  assign port_direction_bit       = ctrl[CTRL_PCD];

  assign wr_eff = cyc_wr & ~port_direction_bit;

  assign avs_waitrequest_out = req & ~resp_done;

  // ==========================================================================
  // Pin input synchroniser
  // ==========================================================================
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else if (ce_in) begin
      pins_meta <= pins_in;
      pins_sync <= pins_meta;
    end
  end

  // ==========================================================================
  // Cycle sequencer
  // ==========================================================================
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = rev17 ? ST_SETUP : ST_WAIT_LOW;
        end
      end
      ST_WAIT_LOW: begin
        if (wd_expire) begin
          next_state = ST_DONE;
        end else if (!wait_high) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_state = wd_expire ? ST_DONE : ST_STROBE;
      end
      ST_STROBE: begin
        if (wait_high || wd_expire) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cyc_wr   <= 1'b0;
      cyc_addr <= 1'b0;
    end else if (ce_in && start) begin
      cyc_wr   <= avs_write_in;
      cyc_addr <= (idx == IDX_EPPADDR);
    end
  end

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  // runs to wait release
  assign wd_expire = (state != ST_IDLE) && (state != ST_DONE) && (wd_cnt == WD_LAST);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wd_cnt <= '0;
    end else if (ce_in) begin
      if (start || state == ST_DONE) begin
        wd_cnt <= '0;
      end else if (state != ST_IDLE && !wd_expire) begin
        wd_cnt <= wd_cnt + WD_W'(1);
      end
    end
  end

  assign timeout_clr = accept & avs_write_in & (idx == IDX_STATUS)
                     & avs_byteenable_in[0] & avs_writedata_in[STAT_TIMEOUT];

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timeout_flag <= 1'b0;
    end else if (ce_in) begin
      if (wd_expire) begin
        timeout_flag <= 1'b1;
      end else if (timeout_clr) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Software registers
  // ==========================================================================
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl <= CTRL_RESET;
      mode <= MODE_RESET;
    end else if (ce_in && accept && avs_write_in && avs_byteenable_in[0]) begin
      if (idx == IDX_CTRL) begin
        ctrl <= avs_writedata_in[CTRL_W-1:0];
      end
      if (idx == IDX_MODE) begin
        mode <= ece_mode_e'(avs_writedata_in[1:0]);
      end
    end
  end

  // One shared byte register: plain data writes and EPP writes both load it,
  // so the last written byte keeps standing on the bus after a cycle ends.
  // hold written byte
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pd_reg <= PD_RESET;
    end else if (ce_in) begin
      if (start && avs_write_in && avs_byteenable_in[0]) begin
        pd_reg <= avs_writedata_in[7:0];
      end else if (accept && avs_write_in && avs_byteenable_in[0] && idx == IDX_DATA) begin
        pd_reg <= avs_writedata_in[7:0];
      end
    end
  end

  // ==========================================================================
  // Bus answer
  // ==========================================================================
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      IDX_DATA: begin
        rd_byte = (mode != MODE_SPP && port_direction_bit) ? pins_sync.parallel_byte_bus : pd_reg;
      end
      IDX_STATUS: begin
        rd_byte = {~pins_sync.peripheral_wait_n, pins_sync.ack_n, pins_sync.paper_end,
                   pins_sync.selected, pins_sync.error_n, 2'b00, timeout_flag};
      end
      IDX_CTRL: begin
        rd_byte = {2'b00, ctrl};
      end
      IDX_MODE: begin
        rd_byte = {6'h00, mode};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Plain registers answer after one cycle; EPP accesses answer from DONE.
  // answer after strobe
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      resp_done        <= 1'b0;
      avs_readdata_out <= RD_RESET;
    end else if (ce_in) begin
      if (resp_done) begin
        resp_done <= 1'b0;
      end else if (state == ST_DONE) begin
        resp_done <= 1'b1;
      end else if (state == ST_IDLE && req && !epp_req) begin
        resp_done        <= 1'b1;
        avs_readdata_out <= {24'h00_0000, rd_byte};
      end
      if (state == ST_STROBE && (wait_high || wd_expire)) begin
        avs_readdata_out <= {24'h00_0000, pins_sync.parallel_byte_bus};
      end
    end
  end

  // ==========================================================================
  // Pin outputs
  // ==========================================================================
  always_comb begin
    next_pins.data_strobe_n        = ~ctrl[CTRL_AUTOFD];
    next_pins.init_n               = ctrl[CTRL_INIT];
    next_pins.addr_strobe_n        = ~ctrl[CTRL_SELIN];
    next_pins.parallel_byte_bus    = pd_reg;
    next_pins.bus_oe               = (mode == MODE_SPP) ? 1'b1 : ~port_direction_bit;
    next_pins.direction_indication = port_direction_bit;
    if (rev17) begin
      next_pins.write_line_n = ~(ctrl[CTRL_STROBE] | ~port_direction_bit);
    end else begin
      next_pins.write_line_n = ~ctrl[CTRL_STROBE];
    end
    if (state == ST_SETUP || state == ST_STROBE) begin
      next_pins.data_strobe_n = 1'b1;
      next_pins.addr_strobe_n = 1'b1;
      if (rev17) begin
        next_pins.bus_oe = ~port_direction_bit | ctrl[CTRL_STROBE];
      end else begin
        next_pins.write_line_n         = ~(wr_eff | ctrl[CTRL_STROBE]);
        next_pins.bus_oe               = wr_eff | ctrl[CTRL_STROBE];
        next_pins.direction_indication = ~wr_eff;
      end
      if (state == ST_STROBE) begin
        next_pins.data_strobe_n = cyc_addr;
        next_pins.addr_strobe_n = ~cyc_addr;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pins_out <= PINS_RESET;
    end else if (ce_in) begin
      pins_out <= next_pins;
    end
  end

endmodule : ece_top

/* ece_checker_assertions.sv */
// Purpose: Concurrent checks on the EPP cycle engine ports.
// Assumes: Control and mode are shadowed from accepted writes.
// Notes:   Host-hold and answer-order checks skip cycles where idle strobe bits are set.
`timescale 1ns/1ps

module ece_checker
  import ece_pkg::*;
#(
  parameter int unsigned WD_COUNT = ece_pkg::WD_CYCLES
) (
  input wire logic                  clk_in,
  input wire logic                  nrst_in,
  input wire logic [ADDR_W-1:0]     avs_address_in,
  input wire logic                  avs_read_in,
  input wire logic                  avs_write_in,
  input wire logic [31:0]           avs_writedata_in,
  input wire logic [3:0]            avs_byteenable_in,
  input wire logic                  avs_waitrequest_out,
  input wire ece_pkg::ece_pins_in_s pins_in,
  input wire ece_pkg::ece_pins_out_s pins_out
);
  // ==========================================================================
  // Shadow state
  // ==========================================================================
  localparam int WDMAX = WD_COUNT + 16;
  logic [5:0] ctrl;
  logic [1:0] mode;
  wire       req     = avs_read_in | avs_write_in;
  wire [3:0] idx     = avs_address_in[5:2];
  wire       epp_idx = (idx >= 4'h3) && (idx <= 4'h7) && mode[1];
  wire       acc     = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire       strb_n  = pins_out.data_strobe_n & pins_out.addr_strobe_n;
  wire       quiet   = !ctrl[1] && !ctrl[3];
  wire       epp19   = mode == 2'b10;
  wire       wl_exp  = !(ctrl[0] || (mode == 2'b11 && !ctrl[5]));

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl <= 6'h00;
    end else if (acc && idx == 4'h2) begin
      ctrl <= avs_writedata_in[5:0];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode <= 2'h0;
    end else if (acc && idx == 4'h8) begin
      mode <= avs_writedata_in[1:0];
    end
  end

  // Stall length is counted, since the full watchdog span exceeds a delay range.
  int unsigned stall;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stall <= 0;
    end else if (req && avs_waitrequest_out) begin
      stall <= stall + 1;
    end else begin
      stall <= 0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  chk_idle_follows_ctrl: assert property (!req [*3] |-> pins_out.write_line_n == wl_exp &&
    pins_out.data_strobe_n == !ctrl[1] && pins_out.addr_strobe_n == !ctrl[3] && pins_out.init_n == ctrl[2]
    && pins_out.bus_oe == (mode == 2'b00 || !ctrl[5])) else $error("idle pins differ from control");
  chk_plain_answer: assert property ($rose(req) && !epp_idx |-> ##[1:3] !avs_waitrequest_out)
    else $error("plain access not answered in time");
  chk_epp_cycle_bound: assert property (stall <= WDMAX)
    else $error("epp cycle outlived the watchdog");
  chk_host_held: assert property (!strb_n && req && epp_idx && quiet |-> avs_waitrequest_out)
    else $error("host answered while strobe active");
  chk_strobe_before_ans: assert property (!avs_waitrequest_out && req && epp_idx && quiet |-> strb_n)
    else $error("answer given before strobe release");
  chk_write_setup: assert property ($fell(strb_n) && epp19 && epp_idx && avs_write_in && !ctrl[5] |->
    !pins_out.write_line_n && pins_out.bus_oe && !pins_out.direction_indication)
    else $error("write strobe without bus set up");
  chk_read_floats: assert property ($fell(strb_n) && epp19 && epp_idx && !ctrl[0] &&
    (avs_read_in || ctrl[5]) |-> pins_out.write_line_n && !pins_out.bus_oe)
    else $error("read strobe with bus driven");
  chk_strobe_forces: assert property (!strb_n && req && epp_idx && ctrl[0] |->
    !pins_out.write_line_n && pins_out.bus_oe) else $error("strobe bit did not force write");
  chk_wait_first: assert property ($rose(req) && epp_idx && epp19 && pins_in.peripheral_wait_n
    ##1 pins_in.peripheral_wait_n [*6] |-> strb_n) else $error("strobe while wait still high");
  chk_hold_byte: assert property (!avs_waitrequest_out && avs_write_in && epp_idx && mode == 2'b11 &&
    !ctrl[5] |-> ##2 pins_out.parallel_byte_bus == $past(avs_writedata_in[7:0], 2) && pins_out.bus_oe)
    else $error("written byte not held");

  cov_rev17: cover property ($rose(req) && epp_idx && mode == 2'b11);
  cov_addr_strobe: cover property ($fell(pins_out.addr_strobe_n) && epp_idx);
  cov_long_cycle: cover property (stall == 20);
endmodule : ece_checker

bind ece_top ece_checker #(.WD_COUNT(WD_COUNT)) u_chk (
  .clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_waitrequest_out(avs_waitrequest_out), .pins_in(pins_in), .pins_out(pins_out)
);

/* ece_periph.sv */
// Purpose: Peripheral partner answering EPP strobes.
// Assumes: Wait idles at hold_in, low by default; an undriven bus shows a toggling pattern.
// Notes:   Mute never releases wait, so the watchdog must end the cycle.
`timescale 1ns/1ps

module ece_periph
  import ece_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire ece_pkg::ece_pins_out_s pins_out,
  input  wire logic [3:0]             delay_in,
  input  wire logic                   mute_in,
  input  wire logic                   hold_in,
  input  wire logic [7:0]             byte_in,
  output ece_pkg::ece_pins_in_s       pins_in,
  output logic [7:0]                  seen_out,
  output logic                        seen_addr_out,
  output logic                        seen_wl_out
);
  // ==========================================================================
  // Handshake
  // ==========================================================================
  logic [3:0] cnt    = 4'h0;
  logic       wait_n = 1'b0;
  logic       drv    = 1'b0;
  logic [7:0] last   = 8'h00;
  wire        strb   = !pins_out.data_strobe_n || !pins_out.addr_strobe_n;

  always_ff @(posedge clk_in) begin
    last <= pins_in.parallel_byte_bus;
    if (!strb) begin
      cnt <= 4'h0;
      drv <= 1'b0;
      wait_n <= hold_in;
    end else begin
      drv <= pins_out.write_line_n;
      seen_out <= pins_out.parallel_byte_bus;
      seen_addr_out <= !pins_out.addr_strobe_n;
      seen_wl_out <= pins_out.write_line_n;
      if (cnt < delay_in) begin
        cnt <= cnt + 4'h1;
      end else if (!mute_in) begin
        wait_n <= 1'b1;
      end
    end
  end

  // A released bus must not hold its old value, or stale reads would pass.
  always_comb begin
    pins_in = '{peripheral_wait_n: wait_n, ack_n: 1'b1, paper_end: 1'b0, selected: 1'b1, error_n: 1'b1,
                parallel_byte_bus: drv ? byte_in : ~last};
  end
endmodule : ece_periph

/* testbench.sv */
// Purpose: Self-checking bench for the EPP cycle engine.
// Assumes: Watchdog shortened to WDC cycles.
// Notes:   Waitrequest is sampled on rising edges; requests change after edges.
`timescale 1ns/1ps

module testbench;
  import ece_pkg::*;
  localparam int unsigned WDC = 30;
  logic              clk_in           = 1'b0;
  logic              nrst_in          = 1'b0;
  logic [ADDR_W-1:0] avs_address_in   = '0;
  logic              avs_read_in      = 1'b0;
  logic              avs_write_in     = 1'b0;
  logic [31:0]       avs_writedata_in = 32'h0000_0000;
  logic [31:0]       avs_readdata_out;
  logic              avs_waitrequest_out;
  ece_pins_in_s      pins_in;
  ece_pins_out_s     pins_out;
  logic [3:0]        delay            = 4'h3;
  logic              mute             = 1'b0;
  logic              hold             = 1'b0;
  logic [7:0]        pbyte            = 8'h00;
  logic [3:0]        be               = 4'h1;
  logic [7:0]        seen;
  logic              seen_addr;
  logic              seen_wl;
  logic [31:0]       q;
  int                n_fail           = 0;
  int                samples_checked  = 0;

  always #2.5 clk_in = ~clk_in;

  ece_top #(.WD_COUNT(WDC)) dut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(be), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .pins_in(pins_in), .pins_out(pins_out));

  ece_periph model (.clk_in(clk_in), .pins_out(pins_out), .delay_in(delay), .mute_in(mute),
    .hold_in(hold), .byte_in(pbyte), .pins_in(pins_in), .seen_out(seen), .seen_addr_out(seen_addr),
    .seen_wl_out(seen_wl));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk_in);
    avs_address_in <= {idx, 2'b00};
    avs_writedata_in <= {24'h00_0000, d};
    avs_write_in <= w;
    avs_read_in <= !w;
    // The request stands until the edge that sees waitrequest low, then drops.
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [3:0] idx);
    bus(1'b0, idx, 8'h00);
  endtask : rd

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(IDX_STATUS);
    check("timeout at reset", {31'h0, q[0]}, 32'h0000_0000);
    wr(IDX_CTRL, 8'h0B);
    repeat (3) @(posedge clk_in);
    check("idle pins", {28'h0, pins_out.write_line_n, pins_out.data_strobe_n, pins_out.addr_strobe_n,
      pins_out.init_n}, 32'h0000_0000);
    wr(IDX_CTRL, 8'h04);
    wr(IDX_MODE, 8'h02);
    for (int i = 3; i < 8; i++) begin
      wr(i[3:0], 8'(i) * 8'h11);
      check("epp write byte", {24'h0, seen}, {24'h0, 8'(i) * 8'h11});
      check("addr strobe", {31'h0, seen_addr}, {31'h0, i == 3});
    end
    pbyte <= 8'h3C;
    rd(4'h5);
    check("epp read", q, 32'h0000_003C);
    hold <= 1'b1;
    fork
      begin
        repeat (10) @(posedge clk_in);
        hold <= 1'b0;
      end
    join_none
    repeat (3) @(posedge clk_in);
    wr(4'h4, 8'h66);
    check("held write", {24'h0, seen}, 32'h0000_0066);
    wr(IDX_CTRL, 8'h05);
    rd(4'h4);
    check("forced write line", {31'h0, seen_wl}, 32'h0000_0000);
    wr(IDX_CTRL, 8'h24);
    wr(4'h4, 8'h77);
    check("read-like write", {31'h0, seen_wl}, 32'h0000_0001);
    rd(IDX_STATUS);
    check("no error", {31'h0, q[0]}, 32'h0000_0000);
    wr(IDX_CTRL, 8'h04);
    mute <= 1'b1;
    wr(4'h4, 8'h12);
    mute <= 1'b0;
    rd(IDX_STATUS);
    check("timeout set", {31'h0, q[0]}, 32'h0000_0001);
    wr(IDX_STATUS, 8'h00);
    rd(IDX_STATUS);
    check("zero keeps flag", {31'h0, q[0]}, 32'h0000_0001);
    wr(IDX_STATUS, 8'h01);
    rd(IDX_STATUS);
    check("one clears flag", {31'h0, q[0]}, 32'h0000_0000);
    wr(IDX_MODE, 8'h03);
    wr(4'h6, 8'h5A);
    repeat (2) @(posedge clk_in);
    check("byte held", {23'h0, pins_out.bus_oe, pins_out.parallel_byte_bus}, 32'h0000_015A);
    mute <= 1'b1;
    wr(4'h4, 8'h01);
    mute <= 1'b0;
    rd(IDX_STATUS);
    check("rev17 timeout", {31'h0, q[0]}, 32'h0000_0001);
    wr(IDX_CTRL, 8'h24);
    pbyte <= 8'hC3;
    rd(4'h7);
    check("rev17 read", q, 32'h0000_00C3);
    rd(4'hC);
    check("unmapped read", q, 32'h0000_0000);
    be <= 4'h0;
    wr(IDX_CTRL, 8'h3F);
    be <= 4'h1;
    rd(IDX_CTRL);
    check("masked write", q, 32'h0000_0024);
    end_sim();
  end

  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule : testbench
